//--- verification/alu_ops_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module alu_ops_asserts (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [7:0] tim_r;
  logic [5:0] cnt_r;
  logic [5:0] exp_r;
  wire logic acc_w;
  wire logic abs_w;
  assign acc_w = psel && penable && pready && pwrite && !pslverr;
  assign abs_w = pwdata[13] && !pwdata[3];
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tim_r <= 8'h00;
      exp_r <= 6'h00;
      cnt_r <= 6'h00;
    end else begin
      if (acc_w && paddr == 8'h04) tim_r <= pwdata[7:0];
      if (acc_w && paddr == 8'h00) exp_r <= 6'h02 + {2'h0, tim_r[3:0]}
        + (abs_w ? {2'h0, tim_r[7:4]} : 6'h00);
      cnt_r <= busy ? cnt_r + 6'h01 : 6'h00;
    end
  end
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  ready_phase_a: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  wait_state_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("answer not after one wait state");
  err_qual_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero when idle");
  busy_refuse_a: assert property (psel && penable && pready && pwrite && busy
    |-> pslverr) else $error("write accepted while busy");
  busy_start_a: assert property ($rose(busy) |-> $past(acc_w && paddr == 8'h00))
    else $error("busy rose without issue");
  busy_min_a: assert property ($rose(busy) |-> busy [*2])
    else $error("operation shorter than two cycles");
  op_length_a: assert property ($fell(busy) |-> cnt_r == exp_r)
    else $error("operation length wrong");
endmodule : alu_ops_asserts
bind xor_extend_abs_alu alu_ops_asserts chk_u (.clk_sys(clk_sys),
  .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .busy(busy));
`default_nettype wire

//--- verification/tb_xor_extend_abs_alu.sv
`timescale 1ns/1ps
`default_nettype none
module tb_xor_extend_abs_alu;
  logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, busy, ev;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  int n_fail, checks_done;
  xor_extend_abs_alu dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    checks_done++;
    if (seen !== ex) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) chk("pready", 32'h0, 32'h1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    chk("write error", {31'h0, ev}, {31'h0, e});
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] x, input logic e,
      input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rv, x);
    chk("read error", {31'h0, ev}, {31'h0, e});
  endtask : rd
  task exec(input logic [31:0] ins, input int n, input logic poke,
      input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi,
      input logic [31:0] cc, input logic [31:0] er, input logic [31:0] sticky_exception_flags);
    int k;
    k = 0;
    wr(8'h00, ins, 1'b0);
    if (poke) begin
      wr(8'h04, 32'h0, 1'b1);
      rd(8'h14, 32'h1, 1'b0, "status busy");
    end
    do begin
      @(posedge clk_sys);
      k++;
    end while (busy === 1'b1 && k < 60);
    if (!poke) chk("cycles", 32'(k), 32'(n + 1));
    if (!$isunknown(lo)) rd(a, lo, 1'b0, "result low");
    rd(a + 8'h04, hi, 1'b0, "result high");
    rd(8'h08, cc, 1'b0, "ccr");
    rd(8'h0c, er, 1'b0, "er");
    rd(8'h10, sticky_exception_flags, 1'b0, "ier");
    $display("test %h done", ins);
  endtask : exec
  initial begin
    #(40 * 5000);
    n_fail++;
    final_report();
  end
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_fail = 0;
    checks_done = 0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int a = 0; a <= 'h14; a += 4) rd(8'(a), 32'h0, 1'b0, "reset");
    rd(8'h40, 32'h0, 1'b0, "reset data");
    rd(8'h80, 32'h0, 1'b1, "unmapped");
    wr(8'h41, 32'h1, 1'b1);
    $display("test map done");
    wr(8'h08, 32'hf3, 1'b0);
    wr(8'h60, 32'h8000_0001, 1'b0);
    wr(8'h64, 32'hbff, 1'b0);
    wr(8'h48, 32'h0000_0001, 1'b0);
    wr(8'h4c, 32'hfff, 1'b0);
    wr(8'h78, 32'h8000_0000, 1'b0);
    wr(8'h7c, 32'h47f, 1'b0);
    wr(8'h58, 32'h8f0f_1234, 1'b0);
    wr(8'h68, 32'h0f0f_1234, 1'b0);
    wr(8'h50, 32'h1234_8001, 1'b0);
    wr(8'h70, 32'habcd_ef00, 1'b0);
    wr(8'h44, 32'h800, 1'b0);
    exec(32'h2134, 2, 1'b0, 8'h60, 32'h8000_0000, 32'h3ff, 32'he3, 32'h01,
      32'h01);
    wr(8'h04, 32'h53, 1'b0);
    exec(32'h0000_e1e1, 10, 1'b1, 8'h48, 32'h4000_0001, 32'h7ff, 32'he3,
      32'h60, 32'h11);
    exec(32'h2137, 10, 1'b0, 8'h78, 32'h0, 32'h7ff, 32'hf3, 32'h09,
      32'h19);
    exec(32'hffff_c52b, 5, 1'b0, 8'h58, 32'h8000_0000, 32'h0, 32'hf9,
      32'h09, 32'h19);
    rd(8'h68, 32'h0f0f_1234, 1'b0, "source kept");
    exec(32'h21ca, 5, 1'b0, 8'h50, 32'hffff_8001, 32'h0, 32'hf9, 32'h09,
      32'h19);
    exec(32'h211e, 5, 1'b0, 8'h70, 32'h0, 32'h0, 32'hf5, 32'h09,
      32'h19);
    exec(32'h2120, 10, 1'b0, 8'h40, 32'h0, 32'h0, 32'he5, 32'h00,
      32'h19);
    wr(8'h00, 32'h3fff, 1'b0);
    rd(8'h14, 32'h2, 1'b0, "illegal issue");
    chk("busy idle", {31'h0, busy}, 32'h0);
    $display("test illegal done");
    final_report();
  end
endmodule : tb_xor_extend_abs_alu
`default_nettype wire

//--- verilog/abs_round_unit.sv
`timescale 1ns/1ps
`default_nettype none

// Absolute value, optionally rounded to single precision (nearest even)
module abs_round_unit (
  abs_unit_if.unit u
);
  wire logic [10:0] exp_in = u.operand[42:32];
  wire logic [31:0] man_in = u.operand[31:0];
  wire logic exp_max = (exp_in == 11'h7ff);
  wire logic is_nan = exp_max && (man_in[30:0] != 31'h0);
  wire logic is_inf = exp_max && (man_in[30:0] == 31'h0);
  wire logic is_zero = !exp_max && (man_in == 32'h0);
  wire logic guard = man_in[7];
  wire logic sticky = |man_in[6:0];
  wire logic round_up = guard && (sticky || man_in[8]);
  wire logic [24:0] man_sum = {1'b0, man_in[31:8]} + {24'h0, round_up};
  wire logic [11:0] exp_sum = {1'b0, exp_in} + {11'h0, man_sum[24]};
  wire logic [23:0] man_rnd = man_sum[24] ? 24'h800000 : man_sum[23:0];
  wire logic lost = |man_in[7:0];
  wire logic sp_ovf = !exp_max && !is_zero && (exp_sum > 12'h47e);
  wire logic sp_unf = !exp_max && !is_zero && (exp_in < 11'h381);
  wire logic sp_num = !exp_max && !is_zero && !sp_ovf && !sp_unf;
  wire logic do_sp = u.single_precision && !exp_max && !is_zero;
  logic [43:0] res;

  always_comb begin
    res = {1'b0, exp_in, man_in}; // [RULE11] [RULE16]
    if (is_nan) begin
      res = {1'b0, exp_in, man_in | 32'h4000_0000};
    end else if (do_sp && sp_ovf) begin
      res = {1'b0, 11'h7ff, 32'h0};
    end else if (do_sp && sp_unf) begin
      res = 44'h0;
    end else if (do_sp) begin
      res = {1'b0, exp_sum[10:0], man_rnd, 8'h00}; // [RULE11]
    end
  end

  assign u.result = res;
  assign u.res_zero = is_zero || (do_sp && sp_unf);
  assign u.res_inf = is_inf || (do_sp && sp_ovf);
  assign u.inexact_status = do_sp && (sp_ovf || sp_unf || (sp_num && lost));
  assign u.underflow_status = do_sp && sp_unf; // [RULE14]
  assign u.overflow_status = do_sp && sp_ovf; // [RULE14]
  assign u.signaling_input_status = is_nan && !man_in[30]; // [RULE15]
  assign u.not_a_number_status = is_nan; // [RULE15]
endmodule : abs_round_unit

`default_nettype wire

//--- verilog/abs_unit_if.sv
`timescale 1ns/1ps
`default_nettype none

interface abs_unit_if;
  logic [43:0] operand;
  logic single_precision;
  logic [43:0] result;
  logic res_zero;
  logic res_inf;
  logic inexact_status;
  logic underflow_status;
  logic overflow_status;
  logic signaling_input_status;
  logic not_a_number_status;

  modport client (
    output operand, single_precision,
    input result, res_zero, res_inf, inexact_status, underflow_status,
    input overflow_status, signaling_input_status, not_a_number_status
  );
  modport unit (
    input operand, single_precision,
    output result, res_zero, res_inf, inexact_status, underflow_status,
    output overflow_status, signaling_input_status, not_a_number_status
  );
endinterface : abs_unit_if

`default_nettype wire

//--- verilog/alu_ops_pkg.sv
package alu_ops_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } exec_state_t;

  typedef enum logic [5:0] {
    OP_NONE = 6'b000001,
    OP_XOR = 6'b000010,
    OP_HALF = 6'b000100,
    OP_BYTE = 6'b001000,
    OP_ABS_S = 6'b010000,
    OP_ABS_X = 6'b100000
  } op_kind_t;

endpackage : alu_ops_pkg

//--- verilog/alu_ops_regs.svh
`ifndef ALU_OPS_REGS_SVH
`define ALU_OPS_REGS_SVH

// Register byte offsets
`define OFS_INSTR 8'h00
`define OFS_TIMING 8'h04
`define OFS_CCR 8'h08
`define OFS_ER 8'h0c
`define OFS_IER 8'h10
`define OFS_STAT 8'h14
`define OFS_DATA_BASE 8'h40

// Condition code byte bit positions
`define CC_C 0
`define CC_V 1
`define CC_Z 2
`define CC_N 3
`define CC_I 4

// Exception status bit positions
`define ER_INX 0
`define ER_DZ 1
`define ER_UNF 2
`define ER_OVF 3
`define ER_OPERAND_ERROR_STATUS 4
`define ER_SIGNALING_INPUT_STATUS 5
`define ER_NAN 6
`define ER_UNORDERED_STATUS 7

// Sticky flag positions
`define IER_INX 0
`define IER_DZ 1
`define IER_UNF 2
`define IER_OVF 3
`define IER_INV 4

// Reset values
`define RST_BYTE 8'h00
`define RST_TIMING 8'h00
`define RST_WORD 32'h0000_0000

// Base cycle count of every operation
`define BASE_CYCLES 6'h02

`endif

//--- verilog/xor_extend_abs_alu.sv
// Behaviour
// [RULE1] Exclusive OR of source and destination low 32 bits into destination.
// [RULE2] XOR opcode: bits 13:12 00, 0sss, uu10, 1ddd below move field.
// [RULE3] Integer ops set Z and N from result, clear V, keep rest.
// [RULE4] Integer ops leave exception status bits unchanged.
// [RULE5] Integer ops leave the sticky exception flags unchanged.
// [RULE6] Integer ops take two cycles plus move extra cycles.
// [RULE7] Half-word widen copies bit 15 into bits 31:16.
// [RULE8] Half-word widen opcode: 10, 0001, uu00, 1ddd.
// [RULE9] Byte widen copies bit 7 into bits 31:8.
// [RULE10] Byte widen opcode: 10, 0001, uu01, 1ddd.
// [RULE11] Single abs clears sign, rounds to single, writes destination.
// [RULE12] Abs opcodes: 10, 0001, uu11 single or uu10 extended, 0ddd.
// [RULE13] Abs ops set Z and I from result, clear N, keep rest.
// [RULE14] Single abs sets inexact, underflow, overflow; clears DZ, OPERAND_ERROR_STATUS, UNORDERED_STATUS.
// [RULE15] Abs ops flag signaling NaN operand and NaN result.
// [RULE16] Extended abs writes without rounding.
// [RULE17] Extended abs clears INEXACT_STATUS, DZ, UNF, OVF, OPERAND_ERROR_STATUS, UNORDERED_STATUS.
// [RULE18] Abs ops accumulate status into sticky flags.
// [RULE19] Abs ops take two cycles plus move and arithmetic extra cycles.
// [RULE20] Three-bit register fields index data registers zero to seven.
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`include "alu_ops_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module xor_extend_abs_alu (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic busy
);
  logic [43:0] dreg_r [8];
  logic [31:0] instr_r;
  logic [7:0] timing_r;
  logic [7:0] condition_code_byte_r;
  logic [7:0] exception_status_bits_r;
  logic [7:0] sticky_exception_flags_r;
  logic illegal_r;
  logic busy_r;
  logic [5:0] cnt_r;
  alu_ops_pkg::exec_state_t state_r;
  alu_ops_pkg::op_kind_t op_r;
  logic [2:0] src_r;
  logic [2:0] dst_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  abs_unit_if abs_bus ();

  abs_round_unit u_abs (
    .u(abs_bus.unit)
  );

  // Opcode field decode
  function automatic alu_ops_pkg::op_kind_t decode_op(
    input logic [31:0] w
  );
    alu_ops_pkg::op_kind_t k;
    k = alu_ops_pkg::OP_NONE;
    if (w[13:12] == 2'b00 && w[11] == 1'b0 && w[5:4] == 2'b10 &&
        w[3] == 1'b1) begin
      k = alu_ops_pkg::OP_XOR; // [RULE2]
    end else if (w[13:12] == 2'b10 && w[11:8] == 4'b0001) begin
      case ({w[5:4], w[3]})
        3'b001: k = alu_ops_pkg::OP_HALF; // [RULE8]
        3'b011: k = alu_ops_pkg::OP_BYTE; // [RULE10]
        3'b110: k = alu_ops_pkg::OP_ABS_S; // [RULE12]
        3'b100: k = alu_ops_pkg::OP_ABS_X; // [RULE12]
        default: k = alu_ops_pkg::OP_NONE;
      endcase
    end
    return k;
  endfunction : decode_op

  // Z and N from a 32-bit integer result, V cleared, others kept
  function automatic logic [7:0] int_cc(
    input logic [7:0] cc,
    input logic [31:0] r
  );
    logic [7:0] n;
    n = cc;
    n[`CC_Z] = (r == 32'h0);
    n[`CC_N] = r[31];
    n[`CC_V] = 1'b0;
    return n;
  endfunction : int_cc

  // APB decode
  wire logic setup_acc = psel && penable && !pready_r;
  wire logic acc_done = psel && penable && pready_r;
  wire logic is_data = (paddr[7:6] == 2'(`OFS_DATA_BASE >> 6));
  wire logic [2:0] data_idx = paddr[5:3];
  wire logic data_hi = paddr[2];
  wire logic hit_instr = (paddr == `OFS_INSTR);
  wire logic hit_timing = (paddr == `OFS_TIMING);
  wire logic hit_ccr = (paddr == `OFS_CCR);
  wire logic hit_er = (paddr == `OFS_ER);
  wire logic hit_ier = (paddr == `OFS_IER);
  wire logic hit_stat = (paddr == `OFS_STAT);
  wire logic aligned = (paddr[1:0] == 2'b00);
  wire logic mapped = aligned && (hit_instr || hit_timing || hit_ccr ||
    hit_er || hit_ier || hit_stat || is_data);
  wire logic acc_err = !mapped || (pwrite && busy_r);
  wire logic wr_ok = acc_done && pwrite && !pslverr_r;
  wire logic issue = wr_ok && hit_instr;
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = `RST_WORD;
    if (is_data && aligned) begin
      rd_mux = data_hi ? {20'h0, dreg_r[data_idx][43:32]}
                       : dreg_r[data_idx][31:0];
    end else if (hit_instr) begin
      rd_mux = instr_r;
    end else if (hit_timing) begin
      rd_mux = {24'h0, timing_r};
    end else if (hit_ccr) begin
      rd_mux = {24'h0, condition_code_byte_r};
    end else if (hit_er) begin
      rd_mux = {24'h0, exception_status_bits_r};
    end else if (hit_ier) begin
      rd_mux = {24'h0, sticky_exception_flags_r};
    end else if (hit_stat) begin
      rd_mux = {30'h0, illegal_r, busy_r};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= `RST_WORD;
    end else begin
      pready_r <= setup_acc;
      pslverr_r <= setup_acc && acc_err;
      prdata_r <= (setup_acc && !pwrite && !acc_err) ? rd_mux : `RST_WORD;
    end
  end

  // Issue decode
  wire alu_ops_pkg::op_kind_t new_op = decode_op(pwdata);
  wire logic new_fp = (new_op == alu_ops_pkg::OP_ABS_S) ||
    (new_op == alu_ops_pkg::OP_ABS_X);
  wire logic [5:0] mv_cycles = {2'b00, timing_r[3:0]};
  wire logic [5:0] da_cycles = new_fp ? {2'b00, timing_r[7:4]} : 6'h0;
  wire logic [5:0] total_cycles = `BASE_CYCLES + mv_cycles + da_cycles;
  wire logic legal = (new_op != alu_ops_pkg::OP_NONE);

  // Execution FSM
  wire logic run = (state_r == alu_ops_pkg::ST_RUN);
  wire logic finish = run && (cnt_r == 6'h0);
  alu_ops_pkg::exec_state_t state_nxt;

  always_comb begin
    case (state_r)
      alu_ops_pkg::ST_IDLE:
        state_nxt = (issue && legal) ? alu_ops_pkg::ST_RUN
                                     : alu_ops_pkg::ST_IDLE;
      alu_ops_pkg::ST_RUN:
        state_nxt = finish ? alu_ops_pkg::ST_IDLE : alu_ops_pkg::ST_RUN;
      default:
        state_nxt = alu_ops_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= alu_ops_pkg::ST_IDLE;
      busy_r <= 1'b0;
      cnt_r <= 6'h0;
    end else begin
      state_r <= state_nxt;
      busy_r <= (state_nxt == alu_ops_pkg::ST_RUN);
      if (issue && legal) begin
        cnt_r <= total_cycles - 6'h1; // [RULE6] [RULE19]
      end else if (run && !finish) begin
        cnt_r <= cnt_r - 6'h1;
      end
    end
  end

  // Operation capture at issue
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      op_r <= alu_ops_pkg::OP_NONE;
      src_r <= 3'h0;
      dst_r <= 3'h0;
    end else if (issue && legal) begin
      op_r <= new_op;
      src_r <= pwdata[10:8]; // [RULE20]
      dst_r <= pwdata[2:0]; // [RULE20]
    end
  end

  // Legality of the last issue
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      illegal_r <= 1'b0;
    end else if (issue) begin
      illegal_r <= !legal;
    end
  end

  // Result datapath
  wire logic [31:0] src_low = dreg_r[src_r][31:0];
  wire logic [31:0] dst_low = dreg_r[dst_r][31:0];
  wire logic [31:0] xor_res = src_low ^ dst_low; // [RULE1]
  wire logic [31:0] half_res = {{16{dst_low[15]}}, dst_low[15:0]}; // [RULE7]
  wire logic [31:0] byte_res = {{24{dst_low[7]}}, dst_low[7:0]}; // [RULE9]
  wire logic is_abs = (op_r == alu_ops_pkg::OP_ABS_S) ||
    (op_r == alu_ops_pkg::OP_ABS_X);
  logic [31:0] int_res;

  always_comb begin
    case (op_r)
      alu_ops_pkg::OP_XOR: int_res = xor_res;
      alu_ops_pkg::OP_HALF: int_res = half_res;
      alu_ops_pkg::OP_BYTE: int_res = byte_res;
      default: int_res = dst_low;
    endcase
  end

  assign abs_bus.operand = dreg_r[dst_r];
  assign abs_bus.single_precision = (op_r == alu_ops_pkg::OP_ABS_S);

  // Floating-point status and flag updates
  logic [7:0] abs_er;
  logic [7:0] abs_cc;
  logic [7:0] abs_ier;

  always_comb begin
    abs_er = 8'h00; // [RULE14] [RULE17]
    abs_er[`ER_INX] = abs_bus.inexact_status; // [RULE14]
    abs_er[`ER_UNF] = abs_bus.underflow_status; // [RULE14]
    abs_er[`ER_OVF] = abs_bus.overflow_status; // [RULE14]
    abs_er[`ER_SIGNALING_INPUT_STATUS] = abs_bus.signaling_input_status; // [RULE15]
    abs_er[`ER_NAN] = abs_bus.not_a_number_status; // [RULE15]
    abs_cc = condition_code_byte_r;
    abs_cc[`CC_Z] = abs_bus.res_zero; // [RULE13]
    abs_cc[`CC_I] = abs_bus.res_inf; // [RULE13]
    abs_cc[`CC_N] = 1'b0; // [RULE13]
    abs_ier = sticky_exception_flags_r; // [RULE18]
    abs_ier[`IER_INX] = abs_ier[`IER_INX] | abs_er[`ER_INX];
    abs_ier[`IER_DZ] = abs_ier[`IER_DZ] | abs_er[`ER_DZ];
    abs_ier[`IER_UNF] = abs_ier[`IER_UNF] | abs_er[`ER_UNF];
    abs_ier[`IER_OVF] = abs_ier[`IER_OVF] | abs_er[`ER_OVF];
    abs_ier[`IER_INV] = abs_ier[`IER_INV] | abs_er[`ER_OPERAND_ERROR_STATUS] |
      abs_er[`ER_SIGNALING_INPUT_STATUS];
  end

  // Software-written control registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      instr_r <= `RST_WORD;
      timing_r <= `RST_TIMING;
    end else if (wr_ok) begin
      if (hit_instr) begin
        instr_r <= pwdata;
      end
      if (hit_timing) begin
        timing_r <= pwdata[7:0];
      end
    end
  end

  // Condition code byte
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      condition_code_byte_r <= `RST_BYTE;
    end else if (finish && is_abs) begin
      condition_code_byte_r <= abs_cc; // [RULE13]
    end else if (finish) begin
      condition_code_byte_r <= int_cc(condition_code_byte_r,
        int_res); // [RULE3]
    end else if (wr_ok && hit_ccr) begin
      condition_code_byte_r <= pwdata[7:0];
    end
  end

  // Exception status bits
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      exception_status_bits_r <= `RST_BYTE;
    end else if (finish && is_abs) begin
      exception_status_bits_r <= abs_er; // [RULE14] [RULE17]
    end else if (finish) begin
      exception_status_bits_r <= exception_status_bits_r; // [RULE4]
    end else if (wr_ok && hit_er) begin
      exception_status_bits_r <= pwdata[7:0];
    end
  end

  // Sticky exception flags
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sticky_exception_flags_r <= `RST_BYTE;
    end else if (finish && is_abs) begin
      sticky_exception_flags_r <= abs_ier; // [RULE18]
    end else if (finish) begin
      sticky_exception_flags_r <= sticky_exception_flags_r; // [RULE5]
    end else if (wr_ok && hit_ier) begin
      sticky_exception_flags_r <= pwdata[7:0];
    end
  end

  // Data registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        dreg_r[i] <= 44'h0;
      end
    end else if (finish && is_abs) begin
      dreg_r[dst_r] <= abs_bus.result; // [RULE11] [RULE16]
    end else if (finish) begin
      dreg_r[dst_r][31:0] <= int_res; // [RULE1] [RULE7] [RULE9]
    end else if (wr_ok && is_data) begin
      if (data_hi) begin
        dreg_r[data_idx][43:32] <= pwdata[11:0];
      end else begin
        dreg_r[data_idx][31:0] <= pwdata;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign busy = busy_r;

endmodule : xor_extend_abs_alu

`default_nettype wire
